// *** rtl/xemi_pkg.sv ***
// Package of constants and types for the external data memory interface.
package xemi_pkg;

    localparam logic [7:0]  XEMI_CFG_ADDR      = 8'ha3;
    localparam logic [7:0]  XEMI_PAGE_ADDR     = 8'haf;
    localparam logic [7:0]  XEMI_CFG_RESET     = 8'h03;
    localparam logic [7:0]  XEMI_PAGE_RESET    = 8'h00;
    localparam logic [7:0]  XEMI_CFG_WMASK     = 8'h3f;
    localparam int          XEMI_PORT_GROUP_SELECT_BIT    = 5;
    localparam int          XEMI_MUXSEL_BIT    = 4;
    localparam int          XEMI_MODE_LSB      = 2;
    localparam int          XEMI_ALE_LSB       = 0;
    localparam logic [15:0] XEMI_ONCHIP_BYTES  = 16'h1000;
    localparam int          XEMI_ONCHIP_AW     = 12;
    localparam logic [3:0]  XEMI_BASE_CYCLES   = 4'h4;
    localparam logic [3:0]  XEMI_STROBE_CYCLES = 4'h1;

    typedef enum logic [1:0] {
        XEMI_MAP_INTERNAL = 2'h0,
        XEMI_MAP_SPLIT_NB = 2'h1,
        XEMI_MAP_SPLIT_BS = 2'h2,
        XEMI_MAP_EXTERNAL = 2'h3
    } xemi_map_e;

    typedef enum logic [5:0] {
        XEMI_IDLE   = 6'b000001,
        XEMI_ALE_HI = 6'b000010,
        XEMI_ALE_LO = 6'b000100,
        XEMI_SETUP  = 6'b001000,
        XEMI_STROBE = 6'b010000,
        XEMI_HOLD   = 6'b100000
    } xemi_state_e;

endpackage

// *** rtl/xemi_ram.sv ***
// On-chip RAM of the external data space, built from flip-flops.
`timescale 1ns/1ps
module xemi_ram #(
    parameter int AW = 12
) (
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rstn,
    // Access port.
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata
);
    logic [7:0] mem_ff [2**AW];
    logic [7:0] rdata_ff;

    // Storage has no reset; only the read register does.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= mem_ff[addr];
        end
    end

    assign rdata = rdata_ff;
endmodule

// *** rtl/xemi_core.sv ***
// External data memory interface: address forming, map decode and off-chip bus sequencer.
`timescale 1ns/1ps
module xemi_core
    import xemi_pkg::*;
#(
    parameter int ONCHIP_AW = xemi_pkg::XEMI_ONCHIP_AW
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rstn,
    // Special function register port from the core.
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    // External move request from the core.
    input  wire logic        mv_req,
    input  wire logic        mv_write,
    input  wire logic        mv_indexed,
    input  wire logic [15:0] data_pointer,
    input  wire logic [7:0]  mv_index,
    input  wire logic [7:0]  mv_wdata,
    input  wire logic [7:0]  addr_high_latch,
    output logic             mv_busy,
    output logic             mv_done,
    output logic      [7:0]  mv_rdata,
    // Off-chip bus pins; output enables are active low, the address latch enable is active high.
    output logic             bus_claim,
    output logic             bus_upper_ports,
    output logic      [7:0]  ad_out,
    output logic      [7:0]  ad_oe_n,
    input  wire logic [7:0]  ad_in,
    output logic      [7:0]  a_lo_out,
    output logic      [7:0]  a_lo_oe_n,
    output logic      [7:0]  a_hi_out,
    output logic      [7:0]  a_hi_oe_n,
    output logic             ale_out,
    output logic             rd_n_out,
    output logic             wr_n_out,
    output logic             ctl_oe_n
);
    import xemi_pkg::*;

    typedef struct packed {
        logic [7:0]  cfg;
        logic [7:0]  page;
        logic [7:0]  sfr_rdata;
        xemi_state_e state;
        logic [3:0]  cnt;
        logic [15:0] addr;
        logic        write;
        logic        drive_hi;
        logic [7:0]  wdata;
        logic [7:0]  ad_sync1;
        logic [7:0]  ad_sync2;
        logic        busy;
        logic        done;
        logic        int_pend;
        logic [7:0]  rdata;
        logic        claim;
        logic        upper;
        logic [7:0]  ad_out;
        logic [7:0]  ad_oe_n;
        logic [7:0]  a_lo;
        logic [7:0]  a_lo_oe_n;
        logic [7:0]  a_hi;
        logic [7:0]  a_hi_oe_n;
        logic        ale;
        logic        rd_n;
        logic        wr_n;
        logic        ctl_oe_n;
    } xemi_s;

    xemi_s st_ff;
    xemi_s nxt_st;

    logic [7:0]           ram_rdata;
    logic                 ram_wr;
    logic [ONCHIP_AW-1:0] ram_addr;

    // Latch-enable high or low phase length in cycles, code 00 gives 1.
    function automatic logic [3:0] ale_len(input logic [1:0] code);
        ale_len = {2'b00, code} + 4'h1;
    endfunction

    // Effective address: pointer form or page:index form.
    function automatic logic [15:0] eff_addr(input logic idx, input logic [15:0] dp,
                                             input logic [7:0] pg, input logic [7:0] ix);
        eff_addr = idx ? {pg, ix} : dp;
    endfunction

    // One match of a register strobe against a register address.
    function automatic logic reg_hit(input logic strobe, input logic [7:0] a, input logic [7:0] target);
        reg_hit = strobe && (a == target);
    endfunction

    // Indexed moves in the no-bank and external-only maps leave the high pins to the port latches.
    function automatic logic hi_released(input logic idx, input logic [1:0] m);
        hi_released = idx && (m == XEMI_MAP_SPLIT_NB || m == XEMI_MAP_EXTERNAL);
    endfunction

    // Setup and hold phases each take the fixed overhead less the take and release edges.
    function automatic logic [3:0] guard_len();
        guard_len = XEMI_BASE_CYCLES - 4'h2;
    endfunction

    logic [15:0] ea;
    logic [1:0]  map;
    logic        offchip;
    logic        muxed;

    always_comb begin
        ea      = eff_addr(mv_indexed, data_pointer, st_ff.page, mv_index);
        map     = st_ff.cfg[XEMI_MODE_LSB +: 2];
        muxed   = ~st_ff.cfg[XEMI_MUXSEL_BIT];
        // Default map after reset is internal only, so moves stay on-chip.
        case (map)
            XEMI_MAP_INTERNAL: offchip = 1'b0;
            XEMI_MAP_EXTERNAL: offchip = 1'b1;
            default:           offchip = (ea >= XEMI_ONCHIP_BYTES);
        endcase
    end

    // On-chip accesses alias onto the populated space by dropping high bits.
    assign ram_addr = ea[ONCHIP_AW-1:0];
    assign ram_wr   = mv_req && !st_ff.busy && mv_write && !offchip;

    xemi_ram #(
        .AW (ONCHIP_AW)
    ) xemi_ram_i (
        .clk   (clk),
        .rstn  (rstn),
        .wr_en (ram_wr),
        .addr  (ram_addr),
        .wdata (mv_wdata),
        .rdata (ram_rdata)
    );

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.done     = 1'b0;
        nxt_st.int_pend = 1'b0;
        nxt_st.ad_sync1 = ad_in;
        nxt_st.ad_sync2 = st_ff.ad_sync1;

        // Register writes and reads.
        if (reg_hit(sfr_wr, sfr_addr, XEMI_CFG_ADDR)) begin
            nxt_st.cfg = sfr_wdata & XEMI_CFG_WMASK;
        end else if (reg_hit(sfr_wr, sfr_addr, XEMI_PAGE_ADDR)) begin
            nxt_st.page = sfr_wdata;
        end
        if (reg_hit(sfr_rd, sfr_addr, XEMI_CFG_ADDR)) begin
            nxt_st.sfr_rdata = st_ff.cfg & XEMI_CFG_WMASK;
        end else if (reg_hit(sfr_rd, sfr_addr, XEMI_PAGE_ADDR)) begin
            nxt_st.sfr_rdata = st_ff.page;
        end else if (sfr_rd) begin
            nxt_st.sfr_rdata = 8'h00;
        end

        // On-chip read data and done return two cycles after the request is taken.
        if (st_ff.int_pend) begin
            nxt_st.rdata = ram_rdata;
            nxt_st.done  = 1'b1;
            nxt_st.busy  = 1'b0;
        end

        case (st_ff.state)
            XEMI_IDLE: begin
                nxt_st.claim    = 1'b0;
                nxt_st.ale      = 1'b0;
                nxt_st.rd_n     = 1'b1;
                nxt_st.wr_n     = 1'b1;
                nxt_st.ctl_oe_n = 1'b1;
                nxt_st.ad_oe_n  = 8'hff;
                nxt_st.a_lo_oe_n = 8'hff;
                nxt_st.a_hi_oe_n = 8'hff;
                if (mv_req && !st_ff.busy) begin
                    nxt_st.busy = 1'b1;
                    if (!offchip) begin
                        nxt_st.int_pend = 1'b1;
                    end else begin
                        nxt_st.write = mv_write;
                        nxt_st.wdata = mv_wdata;
                        nxt_st.upper = st_ff.cfg[XEMI_PORT_GROUP_SELECT_BIT];
                        // Indexed moves in modes 01 and 11 use the port latch as high byte.
                        if (mv_indexed && map == XEMI_MAP_SPLIT_NB) begin
                            nxt_st.addr = {addr_high_latch, mv_index};
                        end else if (mv_indexed && map == XEMI_MAP_EXTERNAL) begin
                            nxt_st.addr = {addr_high_latch, mv_index};
                        end else begin
                            nxt_st.addr = ea;
                        end
                        nxt_st.drive_hi = !hi_released(mv_indexed, map);
                        nxt_st.claim    = 1'b1;
                        nxt_st.ctl_oe_n = 1'b0;
                        nxt_st.a_hi     = nxt_st.addr[15:8];
                        nxt_st.a_hi_oe_n = nxt_st.drive_hi ? 8'h00 : 8'hff;
                        if (muxed) begin
                            nxt_st.state   = XEMI_ALE_HI;
                            nxt_st.cnt     = ale_len(st_ff.cfg[XEMI_ALE_LSB +: 2]);
                            nxt_st.ale     = 1'b1;
                            nxt_st.ad_out  = nxt_st.addr[7:0];
                            nxt_st.ad_oe_n = 8'h00;
                        end else begin
                            nxt_st.state     = XEMI_SETUP;
                            nxt_st.cnt       = guard_len();
                            nxt_st.a_lo      = nxt_st.addr[7:0];
                            nxt_st.a_lo_oe_n = 8'h00;
                            nxt_st.ad_out    = mv_wdata;
                            nxt_st.ad_oe_n   = mv_write ? 8'h00 : 8'hff;
                        end
                    end
                end
            end
            XEMI_ALE_HI: begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.ale   = 1'b0;
                    nxt_st.state = XEMI_ALE_LO;
                    nxt_st.cnt   = ale_len(st_ff.cfg[XEMI_ALE_LSB +: 2]);
                end
            end
            XEMI_ALE_LO: begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.state   = XEMI_SETUP;
                    nxt_st.cnt     = guard_len();
                    nxt_st.ad_out  = st_ff.wdata;
                    nxt_st.ad_oe_n = st_ff.write ? 8'h00 : 8'hff;
                end
            end
            XEMI_SETUP: begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.state = XEMI_STROBE;
                    nxt_st.cnt   = XEMI_STROBE_CYCLES;
                    nxt_st.rd_n  = st_ff.write;
                    nxt_st.wr_n  = !st_ff.write;
                end
            end
            XEMI_STROBE: begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.state = XEMI_HOLD;
                    nxt_st.cnt   = guard_len();
                    nxt_st.rd_n  = 1'b1;
                    nxt_st.wr_n  = 1'b1;
                end
            end
            XEMI_HOLD: begin
                nxt_st.cnt = st_ff.cnt - 4'h1;
                // Read data was captured through the synchroniser at strobe end.
                if (st_ff.cnt == 4'h1) begin
                    nxt_st.state     = XEMI_IDLE;
                    nxt_st.rdata     = st_ff.ad_sync2;
                    nxt_st.done      = 1'b1;
                    nxt_st.busy      = 1'b0;
                    nxt_st.claim     = 1'b0;
                    nxt_st.ctl_oe_n  = 1'b1;
                    nxt_st.ad_oe_n   = 8'hff;
                    nxt_st.a_lo_oe_n = 8'hff;
                    nxt_st.a_hi_oe_n = 8'hff;
                end
            end
            default: begin
                nxt_st.state = XEMI_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff           <= '0;
            st_ff.cfg       <= XEMI_CFG_RESET;
            st_ff.page      <= XEMI_PAGE_RESET;
            st_ff.state     <= XEMI_IDLE;
            st_ff.ad_oe_n   <= 8'hff;
            st_ff.a_lo_oe_n <= 8'hff;
            st_ff.a_hi_oe_n <= 8'hff;
            st_ff.rd_n      <= 1'b1;
            st_ff.wr_n      <= 1'b1;
            st_ff.ctl_oe_n  <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Output drive type stays with the port mode registers; only levels leave here.
    assign sfr_rdata       = st_ff.sfr_rdata;
    assign mv_busy         = st_ff.busy;
    assign mv_done         = st_ff.done;
    assign mv_rdata        = st_ff.rdata;
    assign bus_claim       = st_ff.claim;
    assign bus_upper_ports = st_ff.upper;
    assign ad_out          = st_ff.ad_out;
    assign ad_oe_n         = st_ff.ad_oe_n;
    assign a_lo_out        = st_ff.a_lo;
    assign a_lo_oe_n       = st_ff.a_lo_oe_n;
    assign a_hi_out        = st_ff.a_hi;
    assign a_hi_oe_n       = st_ff.a_hi_oe_n;
    assign ale_out         = st_ff.ale;
    assign rd_n_out        = st_ff.rd_n;
    assign wr_n_out        = st_ff.wr_n;
    assign ctl_oe_n        = st_ff.ctl_oe_n;
endmodule

// *** sim/xemi_core_props.sv ***
// Concurrent checks on the ports of the external data memory interface core.
`timescale 1ns/1ps
module xemi_core_props
    import xemi_pkg::*;
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rstn,
    // Register port.
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    // Move handshake.
    input wire logic       mv_req,
    input wire logic       mv_busy,
    input wire logic       mv_done,
    // Bus pins.
    input wire logic       bus_claim,
    input wire logic       bus_upper_ports,
    input wire logic [7:0] ad_oe_n,
    input wire logic [7:0] a_lo_oe_n,
    input wire logic [7:0] a_hi_oe_n,
    input wire logic       ale_out,
    input wire logic       rd_n_out,
    input wire logic       wr_n_out,
    input wire logic       ctl_oe_n
);
    logic [7:0] cfg_ff;
    logic [2:0] ale_cnt_ff;
    logic       take;

    // The checker keeps its own copy of the configuration written over the register port.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_ff     <= XEMI_CFG_RESET;
            ale_cnt_ff <= 3'h0;
        end else begin
            if (sfr_wr && sfr_addr == XEMI_CFG_ADDR) begin
                cfg_ff <= sfr_wdata & XEMI_CFG_WMASK;
            end
            ale_cnt_ff <= ale_out ? ale_cnt_ff + 3'h1 : 3'h0;
        end
    end
    assign take = mv_req && !mv_busy;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_idle_strobes: assert property (!bus_claim |-> rd_n_out && wr_n_out && !ale_out)
        else $error("strobe or latch enable active outside a move");
    chk_pins_released: assert property (!bus_claim |-> &ad_oe_n && &a_lo_oe_n && &a_hi_oe_n && ctl_oe_n)
        else $error("bus pins driven outside a move");
    chk_read_inputs: assert property (!rd_n_out |-> &ad_oe_n && bus_claim && !ctl_oe_n)
        else $error("data pins driven during a read strobe");
    chk_write_data: assert property (!wr_n_out |-> ad_oe_n == 8'h00 && rd_n_out)
        else $error("data pins not driven during a write strobe");
    chk_ale_width: assert property ($fell(ale_out) |-> ale_cnt_ff == {1'b0, cfg_ff[1:0]} + 3'h1)
        else $error("latch enable high width wrong");
    chk_ale_first: assert property ($rose(bus_claim) && !cfg_ff[4] |-> ale_out && ad_oe_n == 8'h00)
        else $error("multiplexed move does not open with address phase");
    chk_onchip_time: assert property (
        take && cfg_ff[3:2] == 2'h0 |-> ##1 (!mv_done && !bus_claim) ##1 (mv_done && !bus_claim))
        else $error("on-chip move timing or bus use wrong");
    chk_offchip_time: assert property (take && cfg_ff[4:2] == 3'h7 |=> bus_claim ##5 mv_done)
        else $error("off-chip separate-pin move length wrong");
    chk_port_group: assert property ($rose(bus_claim) |-> bus_upper_ports == cfg_ff[5])
        else $error("port group differs from configuration");
    chk_cfg_read: assert property (
        sfr_rd && sfr_addr == XEMI_CFG_ADDR |=> sfr_rdata == {2'b00, cfg_ff[5:0]})
        else $error("configuration read value wrong");

    cov_mux_move: cover property ($fell(ale_out));
    cov_write: cover property (bus_claim && !wr_n_out);
    cov_read: cover property (bus_claim && !rd_n_out);
endmodule

bind xemi_core xemi_core_props xemi_core_props_i (.clk(clk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mv_req(mv_req), .mv_busy(mv_busy),
    .mv_done(mv_done), .bus_claim(bus_claim), .bus_upper_ports(bus_upper_ports), .ad_oe_n(ad_oe_n),
    .a_lo_oe_n(a_lo_oe_n), .a_hi_oe_n(a_hi_oe_n), .ale_out(ale_out), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .ctl_oe_n(ctl_oe_n));

// *** sim/xemi_sram_model.sv ***
// Off-chip byte memory with an address latch in front of its low address lines.
`timescale 1ns/1ps
module xemi_sram_model (
    // Clock and mode.
    input  wire logic       clk,
    input  wire logic       sep_pins,
    // Bus pins.
    input  wire logic       bus_claim,
    input  wire logic [7:0] ad_out,
    input  wire logic [7:0] a_lo_out,
    input  wire logic [7:0] a_hi_out,
    input  wire logic       ale_out,
    input  wire logic       rd_n_out,
    input  wire logic       wr_n_out,
    output logic      [7:0] ad_in
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lat_lo;
    logic [7:0]  last_ff = 8'h00;
    logic        hold_ff = 1'b0;
    logic [15:0] addr;

    always @* if (ale_out) lat_lo = ad_out;
    assign addr = {a_hi_out, sep_pins ? a_lo_out : lat_lo};
    // Read data stands from the strobe until the move lets go of the bus, then the lines float.
    assign ad_in = (!rd_n_out || hold_ff) ? mem[addr] : ~last_ff;
    always @(posedge clk) begin
        last_ff <= ad_in;
        hold_ff <= bus_claim && (hold_ff || !rd_n_out);
        if (!wr_n_out) mem[addr] <= ad_out;
    end
endmodule

// *** sim/external_data_memory_interface_bench.sv ***
// Self-checking bench for the external data memory interface core.
`timescale 1ns/1ps
module external_data_memory_interface_bench;
    import xemi_pkg::*;
    logic        clk, rstn, sfr_wr, sfr_rd, mv_req, mv_write, mv_indexed, sep;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, mv_index, mv_wdata, addr_high_latch, mv_rdata, ad_in;
    logic [15:0] data_pointer;
    logic        mv_busy, mv_done, bus_claim, bus_upper_ports, ale_out, rd_n_out, wr_n_out, ctl_oe_n;
    logic [7:0]  ad_out, ad_oe_n, a_lo_out, a_lo_oe_n, a_hi_out, a_hi_oe_n, rd;
    int          num_errors = 0, compares = 0, n;
    logic        hi_drv, claimed;

    xemi_core xemi_core_i (.clk(clk), .rstn(rstn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mv_req(mv_req), .mv_write(mv_write),
        .mv_indexed(mv_indexed), .data_pointer(data_pointer), .mv_index(mv_index), .mv_wdata(mv_wdata),
        .addr_high_latch(addr_high_latch), .mv_busy(mv_busy), .mv_done(mv_done), .mv_rdata(mv_rdata),
        .bus_claim(bus_claim), .bus_upper_ports(bus_upper_ports), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .ad_in(ad_in), .a_lo_out(a_lo_out), .a_lo_oe_n(a_lo_oe_n), .a_hi_out(a_hi_out), .a_hi_oe_n(a_hi_oe_n),
        .ale_out(ale_out), .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .ctl_oe_n(ctl_oe_n));
    xemi_sram_model xemi_sram_model_i (.clk(clk), .sep_pins(sep), .bus_claim(bus_claim), .ad_out(ad_out),
        .a_lo_out(a_lo_out), .a_hi_out(a_hi_out), .ale_out(ale_out), .rd_n_out(rd_n_out),
        .wr_n_out(wr_n_out), .ad_in(ad_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_count(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        sfr_wr = wr; sfr_rd = !wr; sfr_addr = a; sfr_wdata = d;
        @(posedge clk); #1;
        sfr_wr = 1'b0; sfr_rd = 1'b0;
        @(posedge clk); #1;
    endtask
    task automatic set_cfg(input logic [7:0] c);
        reg_access(1'b1, XEMI_CFG_ADDR, c);
        sep = c[4];
    endtask
    // One move; counts edges from the taking edge to the done pulse and notes pin use meanwhile.
    task automatic move(input logic w, input logic idx, input logic [15:0] ptr, input logic [7:0] ix,
                        input logic [7:0] wd);
        @(posedge clk); #1;
        mv_req = 1'b1; mv_write = w; mv_indexed = idx; data_pointer = ptr; mv_index = ix; mv_wdata = wd;
        @(posedge clk); #1;
        mv_req = 1'b0;
        n = 1; hi_drv = 1'b0; claimed = 1'b0;
        while (mv_done !== 1'b1 && n < 40) begin
            hi_drv |= (a_hi_oe_n !== 8'hff);
            claimed |= (bus_claim === 1'b1);
            @(posedge clk); #1;
            n++;
        end
        rd = mv_rdata;
    endtask

    task automatic test_reset_regs;
        reg_access(1'b0, XEMI_CFG_ADDR, 8'h00);  chk_byte("cfg reset", 8'h03, sfr_rdata);
        reg_access(1'b0, XEMI_PAGE_ADDR, 8'h00); chk_byte("page reset", 8'h00, sfr_rdata);
        reg_access(1'b0, 8'h10, 8'h00);          chk_byte("unmapped", 8'h00, sfr_rdata);
        reg_access(1'b1, XEMI_CFG_ADDR, 8'hff);
        reg_access(1'b0, XEMI_CFG_ADDR, 8'h00);  chk_byte("cfg top bits", 8'h3f, sfr_rdata);
        reg_access(1'b1, XEMI_PAGE_ADDR, 8'h5a);
        reg_access(1'b0, XEMI_PAGE_ADDR, 8'h00); chk_byte("page rw", 8'h5a, sfr_rdata);
        set_cfg(8'h03);
        $display("test_reset_regs done");
    endtask
    task automatic test_onchip_alias;
        move(1'b1, 1'b0, 16'h0123, 8'h00, 8'h5a); chk_count("on-chip time", 2, n);
        move(1'b0, 1'b0, 16'h1123, 8'h00, 8'h00); chk_byte("alias read", 8'h5a, rd);
        reg_access(1'b1, XEMI_PAGE_ADDR, 8'h31);
        move(1'b0, 1'b1, 16'h0000, 8'h23, 8'h00); chk_byte("indexed read", 8'h5a, rd);
        chk_byte("no bus use", 8'h00, {7'h0, claimed});
        $display("test_onchip_alias done");
    endtask
    task automatic test_external_sep;
        set_cfg(8'h3c);
        move(1'b1, 1'b0, 16'h0040, 8'h00, 8'ha5); chk_count("separate time", 6, n);
        chk_byte("pointer write", 8'ha5, xemi_sram_model_i.mem[16'h0040]);
        chk_byte("high pins pointer", 8'h01, {7'h0, hi_drv});
        chk_byte("upper group", 8'h01, {7'h0, bus_upper_ports});
        reg_access(1'b1, XEMI_PAGE_ADDR, 8'h77);
        addr_high_latch = 8'h00;
        move(1'b0, 1'b1, 16'h0000, 8'h40, 8'h00); chk_byte("ext indexed read", 8'ha5, rd);
        chk_byte("high pins indexed", 8'h00, {7'h0, hi_drv});
        $display("test_external_sep done");
    endtask
    task automatic test_split_bank_mux;
        for (int c = 0; c < 4; c++) begin
            set_cfg(8'h08 | 8'(c));
            reg_access(1'b1, XEMI_PAGE_ADDR, 8'h20 + 8'(c));
            move(1'b1, 1'b1, 16'h0000, 8'h10, 8'h30 + 8'(c));
            chk_count("mux time", 6 + 2 * (c + 1), n);
            chk_byte("bank write", 8'h30 + 8'(c), xemi_sram_model_i.mem[{8'h20 + 8'(c), 8'h10}]);
            chk_byte("bank high pins", 8'h01, {7'h0, hi_drv});
            move(1'b0, 1'b1, 16'h0000, 8'h10, 8'h00); chk_byte("mux read", 8'h30 + 8'(c), rd);
        end
        chk_byte("lower group", 8'h00, {7'h0, bus_upper_ports});
        $display("test_split_bank_mux done");
    endtask
    task automatic test_split_nobank;
        set_cfg(8'h14);
        addr_high_latch = 8'h55;
        reg_access(1'b1, XEMI_PAGE_ADDR, 8'h30);
        move(1'b1, 1'b1, 16'h0000, 8'h44, 8'h99);
        chk_byte("latch high write", 8'h99, xemi_sram_model_i.mem[16'h5544]);
        chk_byte("no high pins", 8'h00, {7'h0, hi_drv});
        reg_access(1'b1, XEMI_PAGE_ADDR, 8'h05);
        move(1'b1, 1'b1, 16'h0000, 8'h44, 8'h11); chk_byte("low page on-chip", 8'h00, {7'h0, claimed});
        move(1'b1, 1'b0, 16'h8001, 8'h00, 8'h77);
        chk_byte("pointer split write", 8'h77, xemi_sram_model_i.mem[16'h8001]);
        chk_byte("pointer high pins", 8'h01, {7'h0, hi_drv});
        $display("test_split_nobank done");
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        rstn = 1'b0; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; sep = 1'b0;
        mv_req = 1'b0; mv_write = 1'b0; mv_indexed = 1'b0; data_pointer = 16'h0000; mv_index = 8'h00;
        mv_wdata = 8'h00; addr_high_latch = 8'h00;
        repeat (16) @(posedge clk);
        #1 rstn = 1'b1;
        test_reset_regs();
        test_onchip_alias();
        test_external_sep();
        test_split_bank_mux();
        test_split_nobank();
        give_verdict();
    end
    initial begin
        #100us;
        num_errors++;
        give_verdict();
    end
endmodule
